// *** rtl/ext_alu_pkg.sv ***
// Constants, opcodes and flag layout for the extended ALU datapath.
// Assumes a single core clock and an AHB-Lite master for the registers.
//
// Notes on behaviour
// - Memory XOR: result to accumulator or memory, zero flag only.
// - Immediate XOR: accumulator xor immediate to accumulator, zero only.
// - Extended forms address any data memory section by full address.
// - Add with carry to accumulator, updates five arithmetic flags.
// - Add with carry to memory, same sum and same five flags.
// - Plain add, no carry in, to accumulator or memory, five flags.
// - AND of accumulator and memory, by variant, zero flag only.
// - OR of accumulator and memory, by variant, zero flag only.
// - Clear byte writes zero; bit clear zeroes one bit; no flags.
// - Complement memory byte, to memory or accumulator, zero flag.
// - Decimal adjust adds six to low nibble above nine or aux carry.
// - High nibble adjust above nine or carry; result to memory; carry.
// - Decrement memory byte, to memory or accumulator, zero flag only.
// - Increment memory byte, to memory or accumulator, zero flag only.
// - Move memory to accumulator, no flags change.
// - Move accumulator to memory, no flags change.
// - Rotate memory left, bit seven into bit zero, flags unchanged.
// - Rotate left accumulator variant leaves memory and flags alone.
// - Rotate through carry: old carry to bit zero, bit seven to carry.
package ext_alu_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 9;

    // Register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ACC = 8'h04;
    localparam logic [7:0] REG_FLAGS = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;

    // Control field layout
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_ADDR_LSB = 8;
    localparam int CTRL_IMM_LSB = 20;
    localparam int CTRL_BIT_LSB = 28;
    localparam int CTRL_GO_BIT = 31;

    // Flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_AC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_SC = 4;

    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [3:0] BCD_LIMIT = 4'h9;
    localparam logic [3:0] BCD_FIX = 4'h6;

    typedef enum logic [4:0] {
        xor_to_acc = 5'h00,
        xor_to_memory = 5'h01,
        xor_immediate = 5'h02,
        ext_add_carry_acc = 5'h03,
        ext_add_carry_mem = 5'h04,
        ext_add_acc = 5'h05,
        ext_add_mem = 5'h06,
        ext_and_acc = 5'h07,
        ext_and_mem = 5'h08,
        ext_clear = 5'h09,
        ext_clear_bit = 5'h0a,
        ext_invert_mem = 5'h0b,
        ext_invert_acc = 5'h0c,
        ext_decimal_adjust = 5'h0d,
        ext_decrement_mem = 5'h0e,
        ext_decrement_acc = 5'h0f,
        ext_increment_mem = 5'h10,
        ext_increment_acc = 5'h11,
        ext_move_to_acc = 5'h12,
        ext_move_to_mem = 5'h13,
        ext_or_acc = 5'h14,
        ext_or_mem = 5'h15,
        ext_rotate_left = 5'h16,
        ext_rotate_left_acc = 5'h17,
        ext_rotate_left_carry = 5'h18
    } op_t;
endpackage

// *** rtl/ext_alu_core.sv ***
// Combinational result and flag computation for one operation.
// Assumes operands are stable while the sequencer holds them.
`timescale 1ns/1ps
module ext_alu_core
    import ext_alu_pkg::*;
(
    input wire logic [4:0] op,
    input wire logic [7:0] acc,
    input wire logic [7:0] mem,
    input wire logic [7:0] imm,
    input wire logic [2:0] bit_sel,
    input wire logic [4:0] flags,
    output logic [7:0] result,
    output logic to_mem,
    output logic to_acc,
    output logic needs_mem,
    output logic [4:0] next_flags
);
    function automatic logic is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction

    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] daa;
    logic daa_c;
    logic cin;

    always_comb begin
        result = 8'h00;
        to_mem = 1'b0;
        to_acc = 1'b0;
        needs_mem = 1'b1;
        next_flags = flags;
        cin = 1'b0;
        sum = 9'h000;
        low_sum = 5'h00;
        daa = acc;
        daa_c = flags[FLAG_C];
        case (op_t'(op))
            xor_to_acc, xor_to_memory: begin
                result = acc ^ mem;
                to_acc = (op_t'(op) == xor_to_acc);
                to_mem = ~to_acc;
                next_flags[FLAG_Z] = is_zero(result);
            end
            xor_immediate: begin
                result = acc ^ imm;
                to_acc = 1'b1;
                needs_mem = 1'b0;
                next_flags[FLAG_Z] = is_zero(result);
            end
            ext_add_carry_acc, ext_add_carry_mem,
            ext_add_acc, ext_add_mem: begin
                cin = (op_t'(op) == ext_add_carry_acc ||
                    op_t'(op) == ext_add_carry_mem) ? flags[FLAG_C]
                    : 1'b0;
                sum = {1'b0, acc} + {1'b0, mem} + {8'h00, cin};
                low_sum = {1'b0, acc[3:0]} + {1'b0, mem[3:0]} + {4'h0, cin};
                result = sum[7:0];
                to_acc = (op_t'(op) == ext_add_carry_acc ||
                    op_t'(op) == ext_add_acc);
                to_mem = ~to_acc;
                next_flags[FLAG_C] = sum[8];
                next_flags[FLAG_AC] = low_sum[4];
                next_flags[FLAG_Z] = is_zero(result);
                next_flags[FLAG_OV] = (acc[7] == mem[7]) &&
                    (result[7] != acc[7]);
                next_flags[FLAG_SC] = result[7] ^ next_flags[FLAG_OV];
            end
            ext_and_acc, ext_and_mem: begin
                result = acc & mem;
                to_acc = (op_t'(op) == ext_and_acc);
                to_mem = ~to_acc;
                next_flags[FLAG_Z] = is_zero(result);
            end
            ext_or_acc, ext_or_mem: begin
                result = acc | mem;
                to_acc = (op_t'(op) == ext_or_acc);
                to_mem = ~to_acc;
                next_flags[FLAG_Z] = is_zero(result);
            end
            ext_clear: begin
                result = 8'h00;
                to_mem = 1'b1;
            end
            ext_clear_bit: begin
                result = mem & ~(8'h01 << bit_sel);
                to_mem = 1'b1;
            end
            ext_invert_mem, ext_invert_acc: begin
                result = ~mem;
                to_acc = (op_t'(op) == ext_invert_acc);
                to_mem = ~to_acc;
                next_flags[FLAG_Z] = is_zero(result);
            end
            ext_decimal_adjust: begin
                needs_mem = 1'b0;
                if (acc[3:0] > BCD_LIMIT || flags[FLAG_AC]) begin
                    daa = acc + {4'h0, BCD_FIX};
                end
                if (acc[7:4] > BCD_LIMIT || flags[FLAG_C]) begin
                    {daa_c, daa} = {1'b0, daa} + {1'b0, BCD_FIX, 4'h0};
                    daa_c = 1'b1;
                end
                result = daa;
                to_mem = 1'b1;
                next_flags[FLAG_C] = daa_c | flags[FLAG_C];
            end
            ext_decrement_mem, ext_decrement_acc: begin
                result = mem - 8'h01;
                to_acc = (op_t'(op) == ext_decrement_acc);
                to_mem = ~to_acc;
                next_flags[FLAG_Z] = is_zero(result);
            end
            ext_increment_mem, ext_increment_acc: begin
                result = mem + 8'h01;
                to_acc = (op_t'(op) == ext_increment_acc);
                to_mem = ~to_acc;
                next_flags[FLAG_Z] = is_zero(result);
            end
            ext_move_to_acc: begin
                result = mem;
                to_acc = 1'b1;
            end
            ext_move_to_mem: begin
                result = acc;
                to_mem = 1'b1;
                needs_mem = 1'b0;
            end
            ext_rotate_left, ext_rotate_left_acc: begin
                result = {mem[6:0], mem[7]};
                to_acc = (op_t'(op) == ext_rotate_left_acc);
                to_mem = ~to_acc;
            end
            ext_rotate_left_carry: begin
                result = {mem[6:0], flags[FLAG_C]};
                to_mem = 1'b1;
                next_flags[FLAG_C] = mem[7];
            end
            default: begin
                needs_mem = 1'b0;
            end
        endcase
    end
endmodule

// *** rtl/ext_alu_exec.sv ***
// Top of the extended ALU datapath: AHB-Lite registers and sequencer.
// Assumes a synchronous data memory with one-cycle read latency.
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module ext_alu_exec
    import ext_alu_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic mem_rd,
    output logic mem_wr,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata
);
    typedef enum logic [1:0] {st_idle, st_read, st_exec} state_t;

    state_t state;
    logic [7:0] acc;
    logic [4:0] flags;
    logic [4:0] op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic [7:0] mem_val;
    logic done;
    logic ph_wr;
    logic [7:0] ph_addr;
    logic [7:0] result;
    logic to_mem;
    logic to_acc;
    logic needs_mem;
    logic [4:0] next_flags;
    logic bus_take;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave
    assign bus_take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ph_wr <= 1'b0;
            ph_addr <= 8'h00;
        end else begin
            ph_wr <= bus_take && hwrite;
            if (bus_take) begin
                ph_addr <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (bus_take && !hwrite) begin
            case (haddr[7:0])
                REG_CTRL: hrdata <= {27'h0, op};
                REG_ACC: hrdata <= {24'h0, acc};
                REG_FLAGS: hrdata <= {27'h0, flags};
                REG_STATUS: hrdata <= {30'h0, done, state != st_idle};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operation sequencer
    wire start = ph_wr && ph_addr == REG_CTRL && hwdata[CTRL_GO_BIT] &&
        state == st_idle;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            op <= 5'h00;
            addr <= '0;
            imm <= 8'h00;
            bit_sel <= 3'h0;
        end else if (start) begin
            op <= hwdata[CTRL_OP_LSB +: 5];
            addr <= hwdata[CTRL_ADDR_LSB +: ADDR_W];
            imm <= hwdata[CTRL_IMM_LSB +: 8];
            bit_sel <= hwdata[CTRL_BIT_LSB +: 3];
        end
    end

    ext_alu_core u_core (
        .op(op),
        .acc(acc),
        .mem(mem_val),
        .imm(imm),
        .bit_sel(bit_sel),
        .flags(flags),
        .result(result),
        .to_mem(to_mem),
        .to_acc(to_acc),
        .needs_mem(needs_mem),
        .next_flags(next_flags)
    );

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= st_idle;
            done <= 1'b0;
        end else begin
            case (state)
                st_idle: begin
                    if (start) begin
                        state <= st_read;
                        done <= 1'b0;
                    end
                end
                st_read: state <= st_exec;
                st_exec: begin
                    state <= st_idle;
                    done <= 1'b1;
                end
                default: state <= st_idle;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mem_val <= 8'h00;
        end else if (state == st_read) begin
            mem_val <= mem_rdata;
        end
    end

    assign mem_rd = (state == st_idle) && start;
    // Go cycle shows the new address, every later cycle the latched one
    assign mem_addr = mem_rd ? hwdata[CTRL_ADDR_LSB +: ADDR_W] : addr;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mem_wr <= 1'b0;
            mem_wdata <= 8'h00;
        end else begin
            mem_wr <= (state == st_exec) && to_mem;
            if (state == st_exec && to_mem) begin
                mem_wdata <= result;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator and flags; software may write both while idle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            acc <= ACC_RESET;
        end else if (state == st_exec && to_acc) begin
            acc <= result;
        end else if (ph_wr && ph_addr == REG_ACC && state == st_idle) begin
            acc <= hwdata[7:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags <= FLAGS_RESET;
        end else if (state == st_exec) begin
            flags <= next_flags;
        end else if (ph_wr && ph_addr == REG_FLAGS && state == st_idle) begin
            flags <= hwdata[4:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence exec_s;
        state == st_exec;
    endsequence

    property mem_wr_p;
        @(posedge core_clk) disable iff (rst)
        exec_s and to_mem |=> mem_wr && mem_wdata == $past(result);
    endproperty

    zero_flag_a: assert property (
        @(posedge core_clk) disable iff (rst)
        state == st_exec && (op_t'(op) == ext_and_acc)
        |=> flags[FLAG_Z] == (acc == 8'h00))
        else $error("zero flag wrong after and");
    mem_write_a: assert property (mem_wr_p)
        else $error("memory write missing");
    move_flags_a: assert property (
        @(posedge core_clk) disable iff (rst)
        state == st_exec && op_t'(op) == ext_move_to_acc
        |=> $stable(flags) && acc == $past(mem_val))
        else $error("move altered flags");
    rot_acc_a: assert property (
        @(posedge core_clk) disable iff (rst)
        state == st_exec && op_t'(op) == ext_rotate_left_acc
        |=> !mem_wr && acc == {$past(mem_val[6:0]), $past(mem_val[7])})
        else $error("rotate acc wrong");
    rot_carry_a: assert property (
        @(posedge core_clk) disable iff (rst)
        state == st_exec && op_t'(op) == ext_rotate_left_carry
        |=> flags[FLAG_C] == $past(mem_val[7]))
        else $error("rotate carry wrong");
    xor_imm_a: assert property (
        @(posedge core_clk) disable iff (rst)
        state == st_exec && op_t'(op) == xor_immediate
        |=> acc == ($past(acc) ^ $past(imm)))
        else $error("immediate xor wrong");
    clear_a: assert property (
        @(posedge core_clk) disable iff (rst)
        state == st_exec && op_t'(op) == ext_clear
        |=> mem_wr && mem_wdata == 8'h00 && $stable(flags))
        else $error("clear wrong");
    start_seq_a: assert property (
        @(posedge core_clk) disable iff (rst)
        start |=> state == st_read ##1 exec_s ##1 done)
        else $error("sequence timing wrong");
    wr_addr_a: assert property (
        @(posedge core_clk) disable iff (rst)
        mem_wr |-> mem_addr == addr)
        else $error("memory write address wrong");
    acc_form_a: assert property (
        @(posedge core_clk) disable iff (rst)
        exec_s ##0 to_acc |=> !mem_wr)
        else $error("accumulator form wrote memory");
    bcd_carry_a: assert property (
        @(posedge core_clk) disable iff (rst)
        state == st_exec && op_t'(op) == ext_decimal_adjust
        && flags[FLAG_C] |=> flags[FLAG_C])
        else $error("decimal adjust cleared carry");
endmodule

// *** test/ext_alu_mem_model.sv ***
// Behavioural data memory on the far side of the extended ALU.
// Assumes one core clock; read data follows a read strobe by one edge.
`timescale 1ns/1ps
module ext_alu_mem_model
    import ext_alu_pkg::*;
(
    input wire logic core_clk,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [2**ADDR_W];
    int hold;
    initial begin
        for (int i = 0; i < 2**ADDR_W; i++) begin
            mem[i] = 8'h00;
        end
        mem_rdata = 8'h00;
        hold = 0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Read data stands three cycles, then toggles so stale data never passes
    always @(posedge core_clk) begin
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
        if (mem_rd) begin
            mem_rdata <= mem[mem_addr];
            hold <= 2;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// *** test/tb.sv ***
// Self-checking bench for the extended ALU datapath over AHB-Lite.
// Assumes the memory model above and zero-wait AHB-Lite slave timing.
`timescale 1ns/1ps
module tb;
    import ext_alu_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic mem_rd;
    logic mem_wr;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    int miscompares = 0;
    int cmp_count = 0;
    localparam logic [7:0] SET_ACC [4] = '{8'h7f, 8'h00, 8'h40, 8'ha3};
    localparam logic [7:0] SET_MEM [4] = '{8'h81, 8'hff, 8'h40, 8'h5a};
    localparam logic [4:0] SET_FLG [4] = '{5'h1b, 5'h04, 5'h00, 5'h02};
    localparam logic [7:0] SET_IMM [4] = '{8'h7f, 8'h00, 8'hc3, 8'h3c};
    localparam logic [2:0] SET_BIT [4] = '{3'h7, 3'h0, 3'h6, 3'h3};

    always #25 core_clk = ~core_clk;

    ext_alu_exec dut_u (.core_clk(core_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata));
    ext_alu_mem_model mem_u (.core_clk(core_clk), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata));

    ////////////////////////////////////////////////////////////////////////
    // Comparison, bus and verdict tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic ahb_xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? wd : 32'h0;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask

    task automatic run_op(input op_t op, input logic [8:0] ad,
        input logic [7:0] im, input logic [2:0] bs);
        logic [31:0] rd;
        ahb_xfer(1'b1, REG_CTRL, (32'h1 << CTRL_GO_BIT)
            | (32'(bs) << CTRL_BIT_LSB) | (32'(im) << CTRL_IMM_LSB)
            | (32'(ad) << CTRL_ADDR_LSB) | 32'(op), rd);
        for (int i = 0; i < 50; i++) begin
            ahb_xfer(1'b0, REG_STATUS, 32'h0, rd);
            if (rd[1:0] === 2'b10) break;
        end
        check({30'h0, rd[1:0]}, 32'h2);
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Expected result of one operation
    task automatic ref_op(input op_t op, input logic [7:0] a, m, im,
        input logic [2:0] bs, input logic [4:0] f,
        output logic [7:0] ea, em, output logic [4:0] ef);
        logic [8:0] s;
        logic [7:0] r;
        logic cin, zu, hi, lo;
        ea = a;
        em = m;
        ef = f;
        r = 8'h00;
        zu = 1'b1;
        case (op)
            xor_to_acc, xor_to_memory: r = a ^ m;
            xor_immediate: r = a ^ im;
            ext_add_carry_acc, ext_add_carry_mem, ext_add_acc,
            ext_add_mem: begin
                cin = (op inside {ext_add_carry_acc, ext_add_carry_mem})
                    & f[FLAG_C];
                s = 9'(a) + 9'(m) + 9'(cin);
                r = s[7:0];
                ef[FLAG_C] = s[8];
                ef[FLAG_AC] = (5'(a[3:0]) + 5'(m[3:0]) + 5'(cin)) > 5'd15;
                ef[FLAG_OV] = (a[7] == m[7]) && (r[7] != a[7]);
                ef[FLAG_SC] = r[7] ^ ef[FLAG_OV];
            end
            ext_and_acc, ext_and_mem: r = a & m;
            ext_or_acc, ext_or_mem: r = a | m;
            ext_invert_mem, ext_invert_acc: r = ~m;
            ext_decrement_mem, ext_decrement_acc: r = m - 8'h01;
            ext_increment_mem, ext_increment_acc: r = m + 8'h01;
            default: zu = 1'b0;
        endcase
        case (op)
            ext_clear: r = 8'h00;
            ext_clear_bit: r = m & ~(8'h01 << bs);
            ext_decimal_adjust: begin
                lo = (a[3:0] > BCD_LIMIT) || f[FLAG_AC];
                hi = (a[7:4] > BCD_LIMIT) || f[FLAG_C];
                r = a + {hi ? BCD_FIX : 4'h0, lo ? BCD_FIX : 4'h0};
                ef[FLAG_C] = f[FLAG_C] | hi;
            end
            ext_move_to_acc: r = m;
            ext_move_to_mem: r = a;
            ext_rotate_left, ext_rotate_left_acc:
                r = {m[6:0], m[7]};
            ext_rotate_left_carry: begin
                r = {m[6:0], f[FLAG_C]};
                ef[FLAG_C] = m[7];
            end
            default: ;
        endcase
        if (zu) ef[FLAG_Z] = (r == 8'h00);
        if (op inside {xor_to_memory, ext_add_carry_mem, ext_add_mem,
            ext_and_mem, ext_or_mem, ext_clear, ext_clear_bit,
            ext_invert_mem, ext_decimal_adjust, ext_decrement_mem,
            ext_increment_mem, ext_move_to_mem, ext_rotate_left,
            ext_rotate_left_carry}) em = r;
        else ea = r;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset values, unmapped place, every opcode per set
    initial begin
        logic [31:0] rd;
        logic [7:0] ea, em;
        logic [4:0] ef;
        logic [8:0] ad;
        op_t op;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        ahb_xfer(1'b0, REG_ACC, 32'h0, rd);
        check(rd & 32'hff, {24'h0, ACC_RESET});
        ahb_xfer(1'b0, REG_FLAGS, 32'h0, rd);
        check(rd & 32'h1f, {27'h0, FLAGS_RESET});
        ahb_xfer(1'b0, REG_STATUS, 32'h0, rd);
        check({30'h0, rd[1:0]}, 32'h0);
        ahb_xfer(1'b1, 8'h14, 32'ha5a5a5a5, rd);
        ahb_xfer(1'b0, 8'h14, 32'h0, rd);
        check(rd, 32'h0);
        for (int s = 0; s < 4; s++) begin
            for (int o = 0; o < 25; o++) begin
                op = op_t'(o);
                ad = 9'(o * 21 + s * 170);
                ref_op(op, SET_ACC[s], SET_MEM[s], SET_IMM[s], SET_BIT[s],
                    SET_FLG[s], ea, em, ef);
                ahb_xfer(1'b1, REG_ACC, {24'h0, SET_ACC[s]}, rd);
                ahb_xfer(1'b1, REG_FLAGS, {27'h0, SET_FLG[s]}, rd);
                mem_u.mem[ad] = SET_MEM[s];
                run_op(op, ad, SET_IMM[s], SET_BIT[s]);
                ahb_xfer(1'b0, REG_ACC, 32'h0, rd);
                check(rd & 32'hff, {24'h0, ea});
                ahb_xfer(1'b0, REG_FLAGS, 32'h0, rd);
                check(rd & 32'h1f, {27'h0, ef});
                check({24'h0, mem_u.mem[ad]}, {24'h0, em});
            end
        end
        print_verdict();
    end

    initial begin
        repeat (40000) @(posedge core_clk);
        miscompares++;
        print_verdict();
    end
endmodule
